/* rtl/charger_cfg.svh */
// Purpose: Constants of the charge cycle state controller
// Assumes: 250 MHz bus clock
// Notes:   Definitions only
`ifndef CHARGER_CFG_SVH
`define CHARGER_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS        4
`define POR_TIME_NS          200000
`define OSC_PERIOD_NS        3000000
`define TIMEOUT_STAGES       22
`define TRICKLE_SHIFT        3
`define PRECHARGE_FILTER     4'hF

// ----------------------------------------
// Register map, byte addresses
// ----------------------------------------
`define ADDR_OSC_DIV         8'h00
`define ADDR_STATUS          8'h04
`define ADDR_TIMER           8'h08
`define ADDR_BITS            8

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ST_STATE_LSB         0
`define ST_STATE_MSB         2
`define ST_TMO_BIT           3
`define ST_TEMP_BIT          4

`endif

/* rtl/charger_pkg.sv */
// Purpose: Types of the charge cycle state controller
// Assumes: Constants live in charger_cfg.svh
// Notes:   Gray codes along the usual charge path
package charger_pkg;

  typedef enum logic [2:0] {
    ST_POR      = 3'h0,
    ST_TRICKLE  = 3'h1,
    ST_CC       = 3'h3,
    ST_CV       = 3'h2,
    ST_INHIBIT  = 3'h6,
    ST_FAULT    = 3'h7,
    ST_STANDBY  = 3'h5,
    ST_REMOVED  = 3'h4
  } charge_state_t;

  typedef struct packed {
    logic adapter_input;
    logic charge_enable;
    logic charge_time_limit_enable;
    logic vbat_above_precharge;
    logic vbat_at_termination_voltage;
    logic vbat_below_recharge_voltage_threshold;
    logic temp_window_low_ok;
    logic temp_window_high_ok;
    logic temp_removal;
    logic end_of_charge;
  } sense_t;

endpackage : charger_pkg

/* rtl/sense_sync.sv */
// Purpose: Two-flop synchroniser for a group of comparator levels
// Assumes: Levels are slow against the clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module sense_sync #(
  parameter int WIDTH = 10
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta[i] <= 1'b0;
        q[i]    <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end

endmodule : sense_sync

/* rtl/charge_cycle_state_controller.sv */
// Purpose: Charge cycle sequencing of a single-cell lithium charger
// Assumes: Analog loops outside; comparator results arrive as levels
// Notes:   AHB-Lite slave with zero wait states
//
// How it works
// - Out-of-window temperature stops charging
// - Back in window starts fresh cycle
// - Removal level halts charge, fault active
// - Re-insertion starts a new cycle unless time-out latched
// - During power-on reset: status high, fault low
// - After reset: trickle, then CC, then CV
// - Clean cycle end goes to inhibit
// - Time-out or temperature fault enters fault
// - Adapter absent or enable low means standby
// - Flags encode inhibit/standby, charging, fault
// - Listed events start a new charge cycle
// - Trickle commands one tenth current
// - Fifteen good periods leave trickle
// - Trickle beyond eighth time-out latches fault
// - Termination voltage moves CC to CV
// - Timer cleared entering CC; overrun latches fault
// - Limit enable low disables fast limit
// - End-of-charge current completes CV
// - CC plus CV beyond time-out faults
// - Inhibit restarts below recharge threshold
// - Time-out latch needs power or enable cycle
// - Temperature fault restarts when condition ends
// - Time-out is 2^22 oscillator periods
// - Trickle limit ignores limit enable
`timescale 1ns/1ns
`include "charger_cfg.svh"
module charge_cycle_state_controller
  import charger_pkg::*;
#(
  parameter int          TIMEOUT_STAGES = `TIMEOUT_STAGES,
  parameter int unsigned POR_CYCLES     = (`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned OSC_CYCLES     = `OSC_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        adapter_input,
  input  wire logic        charge_enable,
  input  wire logic        charge_time_limit_enable,
  input  wire logic        vbat_above_precharge,
  input  wire logic        vbat_at_termination_voltage,
  input  wire logic        vbat_below_recharge_voltage_threshold,
  input  wire logic        temp_window_low_ok,
  input  wire logic        temp_window_high_ok,
  input  wire logic        temp_removal,
  input  wire logic        end_of_charge,
  output logic             charge_on,
  output logic             trickle_current_select,
  output logic             cv_mode,
  output logic             status_od_out,
  output logic             status_od_oe,
  output logic             fault_od_out,
  output logic             fault_od_oe
);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  sense_t raw;
  sense_t s;
  logic [$bits(sense_t)-1:0] s_bits;

  assign raw = '{adapter_input, charge_enable, charge_time_limit_enable,
                 vbat_above_precharge, vbat_at_termination_voltage,
                 vbat_below_recharge_voltage_threshold, temp_window_low_ok,
                 temp_window_high_ok, temp_removal, end_of_charge};

  sense_sync #(
    .WIDTH ($bits(sense_t))
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (raw),
    .q     (s_bits)
  );

  assign s = sense_t'(s_bits);

  // ----------------------------------------
  // Registers and bus slave
  // ----------------------------------------
  logic [31:0]               osc_div;
  logic                      wr_pend;
  logic [`ADDR_BITS-1:0]     wr_addr;
  logic                      addr_ok;
  logic [31:0]               next_rdata;
  charge_state_t             state;
  charge_state_t             next_state;
  logic                      tmo_latched;
  logic                      temp_fault;
  logic [TIMEOUT_STAGES:0]   timer;

  assign addr_ok = hsel && htrans[1] && hready;

  always_comb begin
    case (haddr[`ADDR_BITS-1:0])
      `ADDR_OSC_DIV: next_rdata = osc_div;
      `ADDR_STATUS:  next_rdata = {27'h0000000, temp_fault, tmo_latched, state};
      `ADDR_TIMER:   next_rdata = 32'(timer);
      default:       next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr <= haddr[`ADDR_BITS-1:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  // Zero is refused: the period divider would tick only once per 2^32 clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_div <= 32'(OSC_CYCLES);
    end else if (wr_pend && wr_addr == `ADDR_OSC_DIV && hwdata != 32'h00000000) begin
      osc_div <= hwdata;
    end
  end

  // ----------------------------------------
  // Power-on reset and oscillator period
  // ----------------------------------------
  logic [31:0] por_cnt;
  logic        por_done;
  logic [31:0] osc_cnt;
  logic        tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_cnt  <= 32'h00000000;
      por_done <= 1'b0;
    end else if (!por_done) begin
      por_cnt  <= por_cnt + 32'h00000001;
      por_done <= (por_cnt == 32'(POR_CYCLES - 1));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt <= 32'h00000000;
      tick    <= 1'b0;
    end else if (osc_cnt >= osc_div - 32'h00000001) begin
      osc_cnt <= 32'h00000000;
      tick    <= 1'b1;
    end else begin
      osc_cnt <= osc_cnt + 32'h00000001;
      tick    <= 1'b0;
    end
  end

  // ----------------------------------------
  // Condition decode
  // ----------------------------------------
  logic standby_cond;
  logic temp_out;
  logic charging;
  logic fast_tmo;
  logic trickle_tmo;
  logic [3:0] filt;

  assign standby_cond = !s.adapter_input || !s.charge_enable;
  assign temp_out     = !(s.temp_window_low_ok && s.temp_window_high_ok);
  assign charging     = (state == ST_TRICKLE) || (state == ST_CC) || (state == ST_CV);
  // Top stage set means two to the stages periods have passed
  assign fast_tmo     = timer[TIMEOUT_STAGES] && s.charge_time_limit_enable;
  assign trickle_tmo  = |timer[TIMEOUT_STAGES:TIMEOUT_STAGES-`TRICKLE_SHIFT];

  // ----------------------------------------
  // Charge sequence
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_POR:      next_state = por_done ? ST_TRICKLE : ST_POR;
      ST_TRICKLE: begin
        if (trickle_tmo) begin
          next_state = ST_FAULT;
        end else if (filt == `PRECHARGE_FILTER) begin
          next_state = ST_CC;
        end
      end
      ST_CC: begin
        if (fast_tmo) begin
          next_state = ST_FAULT;
        end else if (s.vbat_at_termination_voltage) begin
          next_state = ST_CV;
        end
      end
      ST_CV: begin
        if (fast_tmo) begin
          next_state = ST_FAULT;
        end else if (s.end_of_charge) begin
          next_state = ST_INHIBIT;
        end
      end
      ST_INHIBIT:  next_state = s.vbat_below_recharge_voltage_threshold ? ST_TRICKLE : ST_INHIBIT;
      ST_FAULT:    next_state = (!tmo_latched && !temp_out) ? ST_TRICKLE : ST_FAULT;
      ST_REMOVED:  next_state = tmo_latched ? ST_FAULT : ST_TRICKLE;
      ST_STANDBY:  next_state = ST_TRICKLE;
      default:     next_state = ST_STANDBY;
    endcase
    if (state != ST_POR) begin
      if (standby_cond) begin
        next_state = ST_STANDBY;
      end else if (s.temp_removal) begin
        next_state = ST_REMOVED;
      end else if (state == ST_REMOVED) begin
        next_state = tmo_latched ? ST_FAULT : ST_TRICKLE;
      end else if (charging && temp_out) begin
        next_state = ST_FAULT;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_POR;
    end else begin
      state <= next_state;
    end
  end

  // Latched until standby, which power removal or enable low forces
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmo_latched <= 1'b0;
      temp_fault  <= 1'b0;
    end else begin
      if (standby_cond && state != ST_POR) begin
        tmo_latched <= 1'b0;
      end else if (next_state == ST_FAULT && charging && !temp_out && !s.temp_removal) begin
        tmo_latched <= 1'b1;
      end
      temp_fault <= (next_state == ST_FAULT) && temp_out;
    end
  end

  // ----------------------------------------
  // Charge-time counter and precharge filter
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer <= '0;
    end else if ((next_state == ST_TRICKLE && state != ST_TRICKLE) ||
                 (next_state == ST_CC && state != ST_CC)) begin
      timer <= '0;
    end else if (charging && tick && !timer[TIMEOUT_STAGES]) begin
      timer <= timer + {{TIMEOUT_STAGES{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt <= 4'h0;
    end else if (state != ST_TRICKLE || !s.vbat_above_precharge) begin
      filt <= 4'h0;
    end else if (tick && filt != `PRECHARGE_FILTER) begin
      filt <= filt + 4'h1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open-drain flags: oe high pulls the pin low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_od_oe           <= 1'b0;
      fault_od_oe            <= 1'b1;
      status_od_out          <= 1'b0;
      fault_od_out           <= 1'b0;
      charge_on              <= 1'b0;
      trickle_current_select <= 1'b0;
      cv_mode                <= 1'b0;
    end else begin
      status_od_out          <= 1'b0;
      fault_od_out           <= 1'b0;
      status_od_oe           <= (next_state == ST_TRICKLE) || (next_state == ST_CC) ||
                                (next_state == ST_CV);
      fault_od_oe            <= (next_state == ST_FAULT) || (next_state == ST_REMOVED) ||
                                (next_state == ST_POR);
      charge_on              <= (next_state == ST_TRICKLE) || (next_state == ST_CC) ||
                                (next_state == ST_CV);
      trickle_current_select <= (next_state == ST_TRICKLE);
      cv_mode                <= (next_state == ST_CV);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_por_flags: assert property (state == ST_POR |-> fault_od_oe && !status_od_oe)
    else $error("flags wrong during power-on reset");
  a_charge_flags: assert property (charging |-> status_od_oe && !fault_od_oe && charge_on)
    else $error("flags wrong while charging");
  a_fault_flags: assert property (state == ST_FAULT |-> fault_od_oe && !status_od_oe && !charge_on)
    else $error("flags wrong in fault");
  a_standby_entry: assert property (state != ST_POR && standby_cond |=> state == ST_STANDBY)
    else $error("standby not entered");
  a_removal_wins: assert property (state != ST_POR && !standby_cond && s.temp_removal
                                   |=> state == ST_REMOVED ##0 fault_od_oe)
    else $error("removal not taken");
  a_trickle_exit: assert property (state == ST_TRICKLE ##1 state == ST_CC |-> $past(filt) == `PRECHARGE_FILTER)
    else $error("trickle left early");
  a_cc_clear: assert property (state != ST_CC ##1 state == ST_CC |-> timer == '0)
    else $error("timer not cleared entering CC");
  a_trickle_limit: assert property (state == ST_TRICKLE && trickle_tmo && !standby_cond && !s.temp_removal
                                    && !temp_out |=> state == ST_FAULT && tmo_latched)
    else $error("trickle limit missed");
  a_limit_off: assert property ((state == ST_CC || state == ST_CV) && !s.charge_time_limit_enable && !temp_out
                                && !standby_cond && !s.temp_removal |=> state != ST_FAULT)
    else $error("fault with limit disabled");
  a_trickle_cmd: assert property (trickle_current_select == (state == ST_TRICKLE))
    else $error("trickle command mismatch");

  c_inhibit: cover property (state == ST_CV ##1 state == ST_INHIBIT);
  c_timeout: cover property (tmo_latched && state == ST_FAULT);
  c_removal: cover property (state == ST_REMOVED ##1 state == ST_TRICKLE);
  c_recharge: cover property (state == ST_INHIBIT ##1 state == ST_TRICKLE);

endmodule : charge_cycle_state_controller

/* sim/battery_pack_model.sv */
// Purpose: Battery pack with co-packed thermistor, seen as comparator levels
// Assumes: Bench sets cell voltage, thermistor voltage and current in mV/mA
// Notes:   Current collapses when charging stops, as on a real cell
`timescale 1ns/1ns
module battery_pack_model #(
  parameter int PRECHARGE_MV = 3000,
  parameter int TERM_MV      = 4200,
  parameter int RECHARGE_MV  = 4000,
  parameter int TLOW_MV      = 1505,
  parameter int THIGH_MV     = 305,
  parameter int REMOVE_MV    = 2100,
  parameter int EOC_MA       = 100
) (
  input  wire logic charge_on,
  input  var  int   vbat_mv,
  input  var  int   temp_mv,
  input  var  int   current_ma,
  output logic      vbat_above_precharge,
  output logic      vbat_at_termination_voltage,
  output logic      vbat_below_recharge_voltage_threshold,
  output logic      temp_window_low_ok,
  output logic      temp_window_high_ok,
  output logic      temp_removal,
  output logic      end_of_charge
);
  assign vbat_above_precharge                  = vbat_mv > PRECHARGE_MV;
  assign vbat_at_termination_voltage           = vbat_mv >= TERM_MV;
  assign vbat_below_recharge_voltage_threshold = vbat_mv < RECHARGE_MV;
  assign temp_window_low_ok                    = temp_mv < TLOW_MV;
  assign temp_window_high_ok                   = temp_mv > THIGH_MV;
  assign temp_removal                          = temp_mv >= REMOVE_MV;
  // No current flows unless the charger drives it
  assign end_of_charge = (charge_on ? current_ma : 0) <= EOC_MA;
endmodule : battery_pack_model

/* sim/charge_cycle_state_controller_test.sv */
// Purpose: Self-checking bench of the charge cycle state controller
// Assumes: Short counts: 9 time-out stages, 8 POR cycles, 4 clocks per period
// Notes:   Flag pins are open drain with pull-ups
`timescale 1ns/1ns
`include "charger_cfg.svh"
module charge_cycle_state_controller_test
  import charger_pkg::*;
;
  typedef struct packed {
    logic          ad;
    logic          en;
    int            vb;
    int            tp;
    int            ia;
    int            wt;
    charge_state_t st;
  } row_t;

  logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]   haddr, hwdata, hrdata, rd;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic          adapter_input, charge_enable, charge_time_limit_enable;
  logic          vbat_above_precharge, vbat_at_termination_voltage, vbat_below_recharge_voltage_threshold;
  logic          temp_window_low_ok, temp_window_high_ok, temp_removal, end_of_charge;
  logic          charge_on, trickle_current_select, cv_mode;
  logic          status_od_out, status_od_oe, fault_od_out, fault_od_oe;
  int            vbat_mv, temp_mv, current_ma;
  int            n_fail, checks_done;
  wire           status_pin = status_od_oe ? status_od_out : 1'b1;
  wire           fault_pin  = fault_od_oe ? fault_od_out : 1'b1;
  assign hready = hreadyout;

  row_t rows[14] = '{
    '{1'b1, 1'b1, 2500, 1000, 500, 12, ST_TRICKLE},
    '{1'b1, 1'b1, 3500, 1000, 500, 75, ST_CC},
    '{1'b1, 1'b1, 4200, 1000, 500, 10, ST_CV},
    '{1'b1, 1'b1, 4200, 1000, 50, 10, ST_INHIBIT},
    '{1'b1, 1'b1, 3900, 1000, 500, 10, ST_TRICKLE},
    '{1'b1, 1'b1, 3900, 1000, 500, 75, ST_CC},
    '{1'b1, 1'b1, 3900, 200, 500, 10, ST_FAULT},
    '{1'b1, 1'b1, 3900, 1000, 500, 10, ST_TRICKLE},
    '{1'b1, 1'b1, 3900, 2200, 500, 10, ST_REMOVED},
    '{1'b1, 1'b1, 3900, 1000, 500, 10, ST_TRICKLE},
    '{1'b0, 1'b1, 3900, 1000, 500, 10, ST_STANDBY},
    '{1'b1, 1'b1, 3900, 1000, 500, 10, ST_TRICKLE},
    '{1'b1, 1'b0, 3900, 1000, 500, 10, ST_STANDBY},
    '{1'b1, 1'b1, 3900, 1000, 500, 10, ST_TRICKLE}
  };

  charge_cycle_state_controller #(.TIMEOUT_STAGES(9), .POR_CYCLES(8), .OSC_CYCLES(4)) uut (
    .hclk                                  (hclk),
    .hresetn                               (hresetn),
    .hsel                                  (hsel),
    .haddr                                 (haddr),
    .htrans                                (htrans),
    .hwrite                                (hwrite),
    .hsize                                 (hsize),
    .hwdata                                (hwdata),
    .hready                                (hready),
    .hreadyout                             (hreadyout),
    .hresp                                 (hresp),
    .hrdata                                (hrdata),
    .adapter_input                         (adapter_input),
    .charge_enable                         (charge_enable),
    .charge_time_limit_enable              (charge_time_limit_enable),
    .vbat_above_precharge                  (vbat_above_precharge),
    .vbat_at_termination_voltage           (vbat_at_termination_voltage),
    .vbat_below_recharge_voltage_threshold (vbat_below_recharge_voltage_threshold),
    .temp_window_low_ok                    (temp_window_low_ok),
    .temp_window_high_ok                   (temp_window_high_ok),
    .temp_removal                          (temp_removal),
    .end_of_charge                         (end_of_charge),
    .charge_on                             (charge_on),
    .trickle_current_select                (trickle_current_select),
    .cv_mode                               (cv_mode),
    .status_od_out                         (status_od_out),
    .status_od_oe                          (status_od_oe),
    .fault_od_out                          (fault_od_out),
    .fault_od_oe                           (fault_od_oe)
  );
  battery_pack_model pack (
    .charge_on                             (charge_on),
    .vbat_mv                               (vbat_mv),
    .temp_mv                               (temp_mv),
    .current_ma                            (current_ma),
    .vbat_above_precharge                  (vbat_above_precharge),
    .vbat_at_termination_voltage           (vbat_at_termination_voltage),
    .vbat_below_recharge_voltage_threshold (vbat_below_recharge_voltage_threshold),
    .temp_window_low_ok                    (temp_window_low_ok),
    .temp_window_high_ok                   (temp_window_high_ok),
    .temp_removal                          (temp_removal),
    .end_of_charge                         (end_of_charge)
  );

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check

  task complete_run;
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Waits on hready, never on a fixed count
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge hclk); end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); end while (hready !== 1'b1);
    rd = hrdata;
    check("hresp", hresp, 32'h0);
  endtask : ahb

  task expect_state(input charge_state_t st);
    logic chg;
    chg = st == ST_TRICKLE || st == ST_CC || st == ST_CV;
    check("charge_on", charge_on, chg);
    check("status_pin", status_pin, !chg);
    check("fault_pin", fault_pin, !(st == ST_FAULT || st == ST_REMOVED));
    check("trickle_sel", trickle_current_select, st == ST_TRICKLE);
    check("cv_mode", cv_mode, st == ST_CV);
    ahb(1'b0, `ADDR_STATUS, 32'h0);
    check("state", rd[2:0], st);
  endtask : expect_state

  task toggle_en;
    charge_enable <= 1'b0;
    repeat (5) @(posedge hclk);
    charge_enable <= 1'b1;
    repeat (5) @(posedge hclk);
  endtask : toggle_en

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    #80000;
    n_fail++;
    complete_run();
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {adapter_input, charge_enable, charge_time_limit_enable} = 3'h7;
    vbat_mv = 2500;
    temp_mv = 1000;
    current_ma = 500;
    n_fail = 0;
    checks_done = 0;
    repeat (6) @(posedge hclk);
    check("fault_pin", fault_pin, 1'b0);
    check("status_pin", status_pin, 1'b1);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    check("fault_pin", fault_pin, 1'b0);
    check("status_pin", status_pin, 1'b1);
    // Register map: reset value, refused writes, unmapped read
    ahb(1'b0, `ADDR_OSC_DIV, 32'h0);
    check("osc_div", rd, 32'h4);
    ahb(1'b1, `ADDR_OSC_DIV, 32'h0);
    ahb(1'b1, `ADDR_STATUS, 32'h1F);
    ahb(1'b0, `ADDR_OSC_DIV, 32'h0);
    check("osc_div", rd, 32'h4);
    ahb(1'b0, 8'h0C, 32'h0);
    check("unmapped", rd, 32'h0);
    ahb(1'b1, `ADDR_OSC_DIV, 32'h5);
    ahb(1'b0, `ADDR_OSC_DIV, 32'h0);
    check("osc_div", rd, 32'h5);
    ahb(1'b1, `ADDR_OSC_DIV, 32'h4);
    repeat (10) @(posedge hclk);
    foreach (rows[i]) begin
      adapter_input <= rows[i].ad;
      charge_enable <= rows[i].en;
      vbat_mv <= rows[i].vb;
      temp_mv <= rows[i].tp;
      current_ma <= rows[i].ia;
      repeat (rows[i].wt) @(posedge hclk);
      expect_state(rows[i].st);
      if (rows[i].st == ST_FAULT) begin
        check("fault_bits", rd[4:3], 2'b10);
      end
    end
    // A dip below precharge restarts the 15-period filter
    vbat_mv <= 3500;
    toggle_en();
    repeat (30) @(posedge hclk);
    vbat_mv <= 2500;
    repeat (6) @(posedge hclk);
    vbat_mv <= 3500;
    repeat (30) @(posedge hclk);
    expect_state(ST_TRICKLE);
    repeat (70) @(posedge hclk);
    expect_state(ST_CC);
    // Fast charge limit spans CC plus CV and starts at CC entry
    toggle_en();
    repeat (75) @(posedge hclk);
    expect_state(ST_CC);
    vbat_mv <= 4200;
    repeat (1990) @(posedge hclk);
    expect_state(ST_CV);
    repeat (60) @(posedge hclk);
    expect_state(ST_FAULT);
    check("tmo_bit", rd[3], 1'b1);
    ahb(1'b0, `ADDR_TIMER, 32'h0);
    check("timer", rd, 32'h200);
    repeat (40) @(posedge hclk);
    expect_state(ST_FAULT);
    toggle_en();
    expect_state(ST_TRICKLE);
    // Limit disabled for fast charge only
    charge_time_limit_enable <= 1'b0;
    vbat_mv <= 3500;
    toggle_en();
    repeat (75) @(posedge hclk);
    vbat_mv <= 4200;
    repeat (2200) @(posedge hclk);
    expect_state(ST_CV);
    vbat_mv <= 2500;
    toggle_en();
    repeat (230) @(posedge hclk);
    expect_state(ST_TRICKLE);
    repeat (40) @(posedge hclk);
    expect_state(ST_FAULT);
    check("tmo_bit", rd[3], 1'b1);
    ahb(1'b0, `ADDR_TIMER, 32'h0);
    check("timer", rd, 32'h40);
    adapter_input <= 1'b0;
    repeat (10) @(posedge hclk);
    adapter_input <= 1'b1;
    repeat (10) @(posedge hclk);
    expect_state(ST_TRICKLE);
    complete_run();
  end
endmodule : charge_cycle_state_controller_test
